/* logic/i2cm_cfg.svh */
// Purpose: Offsets, field positions and reset values of the I2C master.
// Assumes: Byte addresses on a 32-bit Avalon-MM slave, 5 address bits.
// Notes:   Definitions only.
`ifndef I2CM_CFG_SVH
`define I2CM_CFG_SVH
// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define I2CM_OFF_RELOAD 5'h00
`define I2CM_OFF_BUF    5'h04
`define I2CM_OFF_CTL1   5'h08
`define I2CM_OFF_CTL2   5'h0c
`define I2CM_OFF_CTL3   5'h10
`define I2CM_OFF_MSK    5'h14
`define I2CM_OFF_STAT   5'h18
`define I2CM_OFF_FLAG   5'h1c
// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define I2CM_B_START   0
`define I2CM_B_RESTART 1
`define I2CM_B_STOP    2
`define I2CM_B_EN    5
`define I2CM_B_WCOL  7
`define I2CM_B_FULL  0
`define I2CM_B_RW    2
`define I2CM_B_S     3
`define I2CM_B_P     4
`define I2CM_B_BCL   0
`define I2CM_B_SEV   1
`define I2CM_MODE_MASTER 4'h8
`define I2CM_LAST_BIT    4'h8
// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define I2CM_RST_REG 8'h00
`endif

/* logic/i2cm_pkg.sv */
// Purpose: Types of the I2C master condition sequencer.
// Assumes: Nothing beyond SystemVerilog.
// Notes:   State machine and the full register state.
package i2cm_pkg;
    // --------------------------------------------------------
    // Sequencer states
    // --------------------------------------------------------
    typedef enum logic [3:0] {
        I2CM_IDLE, I2CM_ST0, I2CM_ST1, I2CM_ST2,
        I2CM_RS0, I2CM_RSH, I2CM_RS1, I2CM_RS2,
        I2CM_SP0, I2CM_SPH, I2CM_SP1, I2CM_SP2,
        I2CM_TXL, I2CM_TXH
    } i2cm_state_t;
    // --------------------------------------------------------
    // All module state
    // --------------------------------------------------------
    typedef struct packed {
        i2cm_state_t st;
        logic [8:0]  cnt;
        logic [7:0]  reload;
        logic [7:0]  shbuf;
        logic [7:0]  shr;
        logic [3:0]  bitn;
        logic [7:0]  ctl1;
        logic [7:0]  ctl2;
        logic [7:0]  ctl3;
        logic [7:0]  msk;
        logic [7:0]  stat;
        logic [1:0]  flag;
        logic        sda_rel;
        logic        scl_rel;
        logic        wait_r;
        logic [31:0] rdata;
    } i2cm_regs_t;
endpackage

/* logic/i2cm_top.sv */
// Purpose: I2C master Start/Restart/Stop sequencer, collision
//          detection and baud rate counter behind Avalon-MM.
// Assumes: SDA/SCL inputs are synchronous to clk_sys_in.
// Notes:   Open-drain pins: output enable low means pull low.
//
// The Avalon-MM register port and the address map are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "i2cm_cfg.svh"
// Operation
// - Start begins: either line already low flags a collision.
// - Such a collision aborts Start, sets the flag, returns to Idle.
// - Data high at Start loads the counter; clock low then collides.
// - Data low during first Start count: reload, pull data low early.
// - Else pull data low at count end, reload, then pull clock low.
// - Restart: release data, count, release clock, data low collides.
// - Restart: data falling before timeout is no collision.
// - Restart: clock falling before data is driven low collides.
// - Restart timeout: pull data low, recount, then pull clock low.
// - Stop: clock released, high, count, then data low collides.
// - Stop: clock low once seen high, before data release, collides.
// - Counter reloads from reload register, starts on buffer write.
// - Finished operation stops counter; clock pin holds its level.
// - Counter reloads twice per serial clock period.
// - Serial clock is oscillator over four times reload plus one.
// - Any collision sets the collision flag and returns to Idle.
// - Collision in transmit halts it, clears buffer full, frees lines.
// - Collision in a condition aborts it, clears its enable bit.
module i2cm_top
    import i2cm_pkg::*;
(
    input  wire logic        clk_sys_in,
    input  wire logic        rst_n_in,
    input  wire logic [4:0]  address_in,
    input  wire logic        read_in,
    input  wire logic        write_in,
    input  wire logic [31:0] writedata_in,
    input  wire logic [3:0]  byteenable_in,
    output logic      [31:0] readdata_out,
    output logic             waitrequest_out,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe_n_out,
    input  wire logic        scl_in,
    output logic             scl_out,
    output logic             scl_oe_n_out
);
    i2cm_regs_t q;
    i2cm_regs_t d;
    logic       wr;
    logic [8:0] ld;
    logic       en;
    logic       coll;
    logic       done;

    // ------------------------------------------------------------
    // Bus decode and helpers
    // ------------------------------------------------------------
    // Write lands on the edge where waitrequest is low
    assign wr  = write_in & ~q.wait_r & byteenable_in[0];
    // Two rollovers of 2*(R+1) cycles make one serial clock period
    assign ld  = {q.reload, 1'b1};
    assign en  = q.ctl1[`I2CM_B_EN] & (q.ctl1[3:0] == `I2CM_MODE_MASTER);

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        d    = q;
        coll = 1'b0;
        done = 1'b0;
        // Request held one cycle with waitrequest high, then answered
        d.wait_r = ~((read_in | write_in) & q.wait_r);
        if ((read_in | write_in) & q.wait_r) begin
            case (address_in)
                `I2CM_OFF_RELOAD: d.rdata = {24'h000000, q.reload};
                `I2CM_OFF_BUF:    d.rdata = {24'h000000, q.shbuf};
                `I2CM_OFF_CTL1:   d.rdata = {24'h000000, q.ctl1};
                `I2CM_OFF_CTL2:   d.rdata = {24'h000000, q.ctl2};
                `I2CM_OFF_CTL3:   d.rdata = {24'h000000, q.ctl3};
                `I2CM_OFF_MSK:    d.rdata = {24'h000000, q.msk};
                `I2CM_OFF_STAT:   d.rdata = {24'h000000, q.stat};
                `I2CM_OFF_FLAG:   d.rdata = {30'h00000000, q.flag};
                default:          d.rdata = 32'h00000000;
            endcase
        end
        // Software writes; hardware events below override them
        if (wr) begin
            case (address_in)
                `I2CM_OFF_RELOAD: d.reload = writedata_in[7:0];
                `I2CM_OFF_CTL1:   d.ctl1 = writedata_in[7:0];
                `I2CM_OFF_CTL3:   d.ctl3 = writedata_in[7:0];
                `I2CM_OFF_MSK:    d.msk = writedata_in[7:0];
                `I2CM_OFF_STAT:   d.stat[7:6] = writedata_in[7:6];
                `I2CM_OFF_CTL2: begin
                    d.ctl2[7] = writedata_in[7];
                    d.ctl2[5:3] = writedata_in[5:3];
                    // Enables only start from Idle; busy writes ignored
                    if (q.st == I2CM_IDLE) begin
                        d.ctl2[2:0] = writedata_in[2:0];
                    end
                end
                `I2CM_OFF_FLAG: begin
                    // Write one to clear
                    d.flag = q.flag & ~writedata_in[1:0];
                end
                `I2CM_OFF_BUF: begin
                    if (q.st == I2CM_IDLE && en && q.ctl2[2:0] == 3'h0) begin
                        d.shbuf = writedata_in[7:0];
                        d.shr = writedata_in[7:0];
                        d.bitn = 4'h0;
                        d.stat[`I2CM_B_FULL] = 1'b1;
                        d.stat[`I2CM_B_RW] = 1'b1;
                        d.scl_rel = 1'b0;
                        d.sda_rel = writedata_in[7];
                        d.cnt = ld;
                        d.st = I2CM_TXL;
                    end else begin
                        d.ctl1[`I2CM_B_WCOL] = 1'b1;
                    end
                end
                default: ;
            endcase
        end
        // Counter runs outside Idle only; Idle freezes it
        if (q.st != I2CM_IDLE && q.cnt != 9'h000) begin
            d.cnt = q.cnt - 9'h001;
        end
        // Condition sequencer
        case (q.st)
            I2CM_IDLE: begin
                if (en && q.ctl2[`I2CM_B_START]) begin
                    d.sda_rel = 1'b1;
                    d.scl_rel = 1'b1;
                    d.st = I2CM_ST0;
                end else if (en && q.ctl2[`I2CM_B_RESTART]) begin
                    d.sda_rel = 1'b1;
                    d.cnt = ld;
                    d.st = I2CM_RS0;
                end else if (en && q.ctl2[`I2CM_B_STOP]) begin
                    d.sda_rel = 1'b0;
                    d.st = I2CM_SP0;
                end
            end
            I2CM_ST0: begin
                if (!sda_in || !scl_in) begin
                    coll = 1'b1;
                end else begin
                    d.cnt = ld;
                    d.st = I2CM_ST1;
                end
            end
            I2CM_ST1: begin
                if (!sda_in) begin
                    // Another master won the race; join it early
                    d.sda_rel = 1'b0;
                    d.cnt = ld;
                    d.st = I2CM_ST2;
                end else if (!scl_in) begin
                    coll = 1'b1;
                end else if (q.cnt == 9'h000) begin
                    d.sda_rel = 1'b0;
                    d.cnt = ld;
                    d.st = I2CM_ST2;
                end
            end
            I2CM_ST2: begin
                // Clock low here is tolerated
                if (q.cnt == 9'h000) begin
                    d.scl_rel = 1'b0;
                    d.stat[`I2CM_B_S] = 1'b1;
                    d.stat[`I2CM_B_P] = 1'b0;
                    done = 1'b1;
                end
            end
            I2CM_RS0: begin
                if (q.cnt == 9'h000) begin
                    d.scl_rel = 1'b1;
                    d.st = I2CM_RSH;
                end
            end
            I2CM_RSH: begin
                if (scl_in) begin
                    if (!sda_in) begin
                        coll = 1'b1;
                    end else begin
                        d.cnt = ld;
                        d.st = I2CM_RS1;
                    end
                end
            end
            I2CM_RS1: begin
                // Data falling alone is not a collision
                if (!scl_in && q.sda_rel) begin
                    coll = 1'b1;
                end else if (q.cnt == 9'h000) begin
                    d.sda_rel = 1'b0;
                    d.cnt = ld;
                    d.st = I2CM_RS2;
                end
            end
            I2CM_RS2: begin
                if (q.cnt == 9'h000) begin
                    d.scl_rel = 1'b0;
                    d.stat[`I2CM_B_S] = 1'b1;
                    done = 1'b1;
                end
            end
            I2CM_SP0: begin
                if (!sda_in) begin
                    d.scl_rel = 1'b1;
                    d.st = I2CM_SPH;
                end
            end
            I2CM_SPH: begin
                // Wait out clock stretching before timing
                if (scl_in) begin
                    d.cnt = ld;
                    d.st = I2CM_SP1;
                end
            end
            I2CM_SP1: begin
                if (!scl_in) begin
                    coll = 1'b1;
                end else if (q.cnt == 9'h000) begin
                    d.sda_rel = 1'b1;
                    d.cnt = ld;
                    d.st = I2CM_SP2;
                end
            end
            I2CM_SP2: begin
                if (q.cnt == 9'h000) begin
                    if (!sda_in) begin
                        coll = 1'b1;
                    end else begin
                        d.stat[`I2CM_B_P] = 1'b1;
                        d.stat[`I2CM_B_S] = 1'b0;
                        done = 1'b1;
                    end
                end
            end
            I2CM_TXL: begin
                if (q.cnt == 9'h000) begin
                    d.scl_rel = 1'b1;
                    d.cnt = ld;
                    d.st = I2CM_TXH;
                end
            end
            I2CM_TXH: begin
                if (q.cnt == 9'h000) begin
                    // Acknowledge slot is the slave's, never a collision
                    if (q.bitn != `I2CM_LAST_BIT && q.sda_rel && !sda_in) begin
                        coll = 1'b1;
                    end else if (q.bitn == `I2CM_LAST_BIT) begin
                        d.scl_rel = 1'b0;
                        d.stat[`I2CM_B_FULL] = 1'b0;
                        d.stat[`I2CM_B_RW] = 1'b0;
                        done = 1'b1;
                    end else begin
                        d.bitn = q.bitn + 4'h1;
                        d.shr = {q.shr[6:0], 1'b0};
                        d.sda_rel = (q.bitn == 4'h7) | q.shr[6];
                        d.scl_rel = 1'b0;
                        d.cnt = ld;
                        d.st = I2CM_TXL;
                    end
                end
            end
            default: d.st = I2CM_IDLE;
        endcase
        // Completion: self-clearing enables drop, event raised
        if (done) begin
            d.ctl2[2:0] = 3'h0;
            d.flag[`I2CM_B_SEV] = 1'b1;
            d.st = I2CM_IDLE;
        end
        // Collision: abort, free both lines, back to Idle
        if (coll) begin
            d.flag[`I2CM_B_BCL] = 1'b1;
            d.ctl2[2:0] = 3'h0;
            d.stat[`I2CM_B_FULL] = 1'b0;
            d.stat[`I2CM_B_RW] = 1'b0;
            d.sda_rel = 1'b1;
            d.scl_rel = 1'b1;
            d.st = I2CM_IDLE;
        end
        // Disabled port frees the pins and clears bus status
        if (!en) begin
            d.st = I2CM_IDLE;
            d.sda_rel = 1'b1;
            d.scl_rel = 1'b1;
            d.ctl2[2:0] = 3'h0;
            d.stat[`I2CM_B_S] = 1'b0;
            d.stat[`I2CM_B_P] = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            q <= '0;
            q.st <= I2CM_IDLE;
            q.reload <= `I2CM_RST_REG;
            q.sda_rel <= 1'b1;
            q.scl_rel <= 1'b1;
            q.wait_r <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // Pins: value and enable share the release flop
    assign sda_out         = q.sda_rel;
    assign sda_oe_n_out    = q.sda_rel;
    assign scl_out         = q.scl_rel;
    assign scl_oe_n_out    = q.scl_rel;
    assign readdata_out    = q.rdata;
    assign waitrequest_out = q.wait_r;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);

    property p_start_busy;
        q.st == I2CM_ST0 && en && !sda_in
        |=> q.flag[`I2CM_B_BCL] && q.st == I2CM_IDLE;
    endproperty
    a_start_busy: assert property (p_start_busy)
        else $error("start on low data not flagged");

    property p_start_abort;
        q.st == I2CM_ST0 && en && !scl_in
        |=> !q.ctl2[`I2CM_B_START] && q.sda_rel && q.scl_rel;
    endproperty
    a_start_abort: assert property (p_start_abort)
        else $error("start not aborted on low clock");

    property p_start_early;
        q.st == I2CM_ST1 && en && !sda_in
        |=> !q.sda_rel && q.st == I2CM_ST2 && q.cnt == ld;
    endproperty
    a_start_early: assert property (p_start_early)
        else $error("early data drive missing");

    property p_start_clk;
        q.st == I2CM_ST2 && en && q.cnt == 9'h000
        |=> !q.scl_rel && !q.sda_rel && q.st == I2CM_IDLE;
    endproperty
    a_start_clk: assert property (p_start_clk)
        else $error("start did not end with clock low");

    property p_rs_clk;
        q.st == I2CM_RS1 && en && !scl_in && q.sda_rel
        |=> $rose(q.flag[`I2CM_B_BCL]) || q.flag[`I2CM_B_BCL];
    endproperty
    a_rs_clk: assert property (p_rs_clk)
        else $error("restart clock collision missed");

    property p_stop_data;
        q.st == I2CM_SP2 && en && q.cnt == 9'h000 && !sda_in
        |=> q.flag[`I2CM_B_BCL] && !q.ctl2[`I2CM_B_STOP];
    endproperty
    a_stop_data: assert property (p_stop_data)
        else $error("stop data collision missed");

    property p_stop_clk;
        q.st == I2CM_SP1 && en && !scl_in
        |=> q.st == I2CM_IDLE && q.scl_rel && q.sda_rel;
    endproperty
    a_stop_clk: assert property (p_stop_clk)
        else $error("stop clock collision missed");

    property p_idle_hold;
        q.st == I2CM_IDLE && en && q.ctl2[2:0] == 3'h0 && !wr
        |=> $stable(q.scl_rel) && $stable(q.cnt);
    endproperty
    a_idle_hold: assert property (p_idle_hold)
        else $error("clock or counter moved in idle");

    property p_half_period;
        q.st == I2CM_TXL && en && q.cnt == 9'h000
        |=> q.st == I2CM_TXH && q.cnt == ld ##1 q.cnt == ld - 9'h001;
    endproperty
    a_half_period: assert property (p_half_period)
        else $error("reload at half period wrong");

    property p_tx_coll;
        coll && q.st == I2CM_TXH
        |=> !q.stat[`I2CM_B_FULL] && q.sda_rel && q.scl_rel;
    endproperty
    a_tx_coll: assert property (p_tx_coll)
        else $error("transmit not halted on collision");

    property p_flag_sticky;
        q.flag[`I2CM_B_BCL] && !wr |=> q.flag[`I2CM_B_BCL];
    endproperty
    a_flag_sticky: assert property (p_flag_sticky)
        else $error("collision flag lost");

    c_start: cover property (q.st == I2CM_ST2 ##1 q.st == I2CM_IDLE);
    c_stop:  cover property (q.st == I2CM_SP2 ##1 q.stat[`I2CM_B_P]);
    c_coll:  cover property ($rose(q.flag[`I2CM_B_BCL]));
    c_tx:    cover property ($fell(q.stat[`I2CM_B_FULL]));
endmodule
`default_nettype wire

/* test/i2cm_bus_model.sv */
// Purpose: Shared open-drain I2C wires with a second party on them.
// Assumes: Pull-ups on both lines; the other party only pulls low.
// Notes:   The bench commands the other party to hold either line low.
`timescale 1ns/100ps
`default_nettype none
module i2cm_bus_model (
    input  wire logic sda_oe_n_in,
    input  wire logic scl_oe_n_in,
    input  wire logic hold_sda_in,
    input  wire logic hold_scl_in,
    output logic      sda_out,
    output logic      scl_out
);
    // --------------------------------------------------------
    // Wired-AND resolution
    // --------------------------------------------------------
    // Released lines rise through the pull-up, never keep a stale level
    assign sda_out = sda_oe_n_in & ~hold_sda_in;
    assign scl_out = scl_oe_n_in & ~hold_scl_in;
endmodule
`default_nettype wire

/* test/tb.sv */
// Purpose: Self-checking bench of the I2C condition sequencer.
// Assumes: Avalon-MM master tasks; bus model resolves open drain.
// Notes:   Reload values kept at 3 and above.
`timescale 1ns/100ps
`default_nettype none
`include "i2cm_cfg.svh"
module tb;
    // --------------------------------------------------------
    // Signals
    // --------------------------------------------------------
    localparam logic [4:0] a_rld = `I2CM_OFF_RELOAD;
    localparam logic [4:0] a_buf = `I2CM_OFF_BUF;
    localparam logic [4:0] a_ct1 = `I2CM_OFF_CTL1;
    localparam logic [4:0] a_ct2 = `I2CM_OFF_CTL2;
    localparam logic [4:0] a_msk = `I2CM_OFF_MSK;
    localparam logic [4:0] a_st  = `I2CM_OFF_STAT;
    localparam logic [4:0] a_fl  = `I2CM_OFF_FLAG;
    logic        clk_sys_in, rst_n_in, read_in, write_in;
    logic [4:0]  address_in;
    logic [31:0] writedata_in, readdata_out;
    logic        waitrequest_out, sda_in, sda_out, sda_oe_n_out;
    logic        scl_in, scl_out, scl_oe_n_out, hold_sda, hold_scl;
    int          miscompares, total_checks;

    i2cm_top i2cm_top_inst (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
        .address_in(address_in), .read_in(read_in), .write_in(write_in),
        .writedata_in(writedata_in), .byteenable_in(4'h1),
        .readdata_out(readdata_out), .waitrequest_out(waitrequest_out),
        .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n_out(sda_oe_n_out),
        .scl_in(scl_in), .scl_out(scl_out), .scl_oe_n_out(scl_oe_n_out));
    i2cm_bus_model i2cm_bus_model_inst (.sda_oe_n_in(sda_oe_n_out),
        .scl_oe_n_in(scl_oe_n_out), .hold_sda_in(hold_sda),
        .hold_scl_in(hold_scl), .sda_out(sda_in), .scl_out(scl_in));

    // --------------------------------------------------------
    // Shared tasks
    // --------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] e, g);
        total_checks++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // One Avalon access; request held until waitrequest is seen low
    task automatic bus(input logic we, input logic [4:0] a,
                       input logic [7:0] d, output logic [31:0] q);
        @(posedge clk_sys_in);
        address_in   <= a;
        writedata_in <= {24'h000000, d};
        write_in     <= we;
        read_in      <= ~we;
        do @(posedge clk_sys_in); while (waitrequest_out !== 1'b0);
        q = readdata_out;
        write_in <= 1'b0;
        read_in  <= 1'b0;
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rdc(input string nm, input logic [4:0] a,
                       input logic [31:0] m, e);
        logic [31:0] q;
        bus(1'b0, a, 8'h00, q);
        chk(nm, e, q & m);
    endtask
    // Edges until an enable reaches a level; bounded so a hang shows
    task automatic wt(input bit scl, input logic lvl, output int n);
        n = 0;
        @(posedge clk_sys_in);
        while (((scl ? scl_oe_n_out : sda_oe_n_out) !== lvl) && n < 1000) begin
            n++;
            @(posedge clk_sys_in);
        end
    endtask

    // --------------------------------------------------------
    // Scenarios
    // --------------------------------------------------------
    task automatic t_regs;
        rdc("flag rst", a_fl, 32'hffffffff, 32'h0);
        rdc("stat rst", a_st, 32'hffffffff, 32'h0);
        wr(a_msk, 8'ha5);
        rdc("mask rw", a_msk, 32'hffffffff, 32'ha5);
        wr(5'h1e, 8'h77);
        rdc("unmapped", 5'h1e, 32'hffffffff, 32'h0);
        wr(a_ct1, 8'h28);
        rdc("ctl1 rw", a_ct1, 32'hffffffff, 32'h28);
        $display("t_regs done");
    endtask
    task automatic t_start(input logic [7:0] r);
        int n;
        wr(a_rld, r);
        rdc("reload rw", a_rld, 32'hff, {24'h0, r});
        wr(a_ct2, 8'h01);
        wt(1'b0, 1'b0, n);
        wt(1'b1, 1'b0, n);
        chk("start tbrg", 2 * (r + 1), n + 1);
        repeat (20) @(posedge clk_sys_in);
        chk("scl held", 32'h0, {scl_oe_n_out, scl_out});
        rdc("start clr", a_ct2, 32'h1, 32'h0);
        rdc("event", a_fl, 32'h3, 32'h2);
        rdc("s bit", a_st, 32'h8, 32'h8);
        wr(a_fl, 8'h03);
        $display("t_start done");
    endtask
    task automatic t_stop(input logic [7:0] r);
        int n;
        wr(a_ct2, 8'h04);
        wt(1'b1, 1'b1, n);
        wt(1'b0, 1'b1, n);
        chk("stop tbrg", 1, n + 1 >= 2 * (r + 1) && n <= 2 * (r + 1));
        repeat (4 * (r + 1)) @(posedge clk_sys_in);
        rdc("p bit", a_st, 32'h10, 32'h10);
        rdc("stop clr", a_ct2, 32'h4, 32'h0);
        rdc("no coll", a_fl, 32'h1, 32'h0);
        $display("t_stop done");
    endtask
    // Other party holds one line low before Start begins
    task automatic t_coll_start;
        for (int i = 0; i < 2; i++) begin
            @(posedge clk_sys_in);
            hold_sda <= (i == 0);
            hold_scl <= (i == 1);
            wr(a_ct2, 8'h01);
            repeat (10) @(posedge clk_sys_in);
            chk("released", 4'hf,
                {sda_oe_n_out, scl_oe_n_out, sda_out, scl_out});
            rdc("coll flag", a_fl, 32'h1, 32'h1);
            rdc("sen clr", a_ct2, 32'h1, 32'h0);
            hold_sda <= 1'b0;
            hold_scl <= 1'b0;
            repeat (5) @(posedge clk_sys_in);
            rdc("flag kept", a_fl, 32'h1, 32'h1);
            wr(a_fl, 8'h03);
            rdc("flag clr", a_fl, 32'h1, 32'h0);
        end
        $display("t_coll_start done");
    endtask
    // Other party pulls data low early in the first Start count
    task automatic t_early;
        int n;
        wr(a_rld, 8'h0a);
        wr(a_ct2, 8'h01);
        repeat (4) @(posedge clk_sys_in);
        hold_sda <= 1'b1;
        wt(1'b0, 1'b0, n);
        chk("early pull", 1, n < 4);
        hold_sda <= 1'b0;
        wt(1'b1, 1'b0, n);
        rdc("early ok", a_fl, 32'h1, 32'h0);
        wr(a_fl, 8'h03);
        $display("t_early done");
    endtask
    // Restart, with the data line held low by the other party if coll
    task automatic t_restart(input bit coll);
        int n;
        wr(a_ct2, 8'h02);
        wt(1'b0, 1'b1, n);
        hold_sda <= coll;
        wr(a_buf, 8'h55);
        rdc("wcol", a_ct1, 32'h80, 32'h80);
        wr(a_ct1, 8'h28);
        if (coll) begin
            repeat (70) @(posedge clk_sys_in);
            chk("rs released", 2'b11, {sda_oe_n_out, scl_oe_n_out});
            hold_sda <= 1'b0;
        end
        else begin
            wt(1'b0, 1'b0, n);
            wt(1'b1, 1'b0, n);
            chk("rs tbrg", 22, n + 1);
        end
        rdc("rs coll", a_fl, 32'h1, {31'h0, coll});
        rdc("rs clr", a_ct2, 32'h2, 32'h0);
        wr(a_fl, 8'h03);
        $display("t_restart done");
    endtask
    // Other party pulls a line low mid-condition
    task automatic t_late(input logic [7:0] c, input bit on_scl, input int k);
        wr(a_ct2, c);
        repeat (k) @(posedge clk_sys_in);
        hold_scl <= on_scl;
        hold_sda <= ~on_scl;
        repeat (60) @(posedge clk_sys_in);
        chk("late rel", 2'b11, {sda_oe_n_out, scl_oe_n_out});
        rdc("late coll", a_fl, 32'h1, 32'h1);
        rdc("late clr", a_ct2, {24'h0, c}, 32'h0);
        hold_sda <= 1'b0;
        hold_scl <= 1'b0;
        wr(a_fl, 8'h03);
        $display("t_late done");
    endtask
    // Byte transmit; other party holds data low in the collision run
    task automatic t_tx(input bit coll);
        wr(a_buf, 8'ha5);
        hold_sda <= coll;
        rdc("tx busy", a_st, 32'h5, 32'h5);
        repeat (500) @(posedge clk_sys_in);
        rdc("tx idle", a_st, 32'h5, 32'h0);
        rdc("tx flag", a_fl, 32'h3, coll ? 32'h1 : 32'h2);
        chk("tx scl", {31'h0, coll}, scl_oe_n_out);
        hold_sda <= 1'b0;
        wr(a_fl, 8'h03);
        $display("t_tx done");
    endtask

    // --------------------------------------------------------
    // Clock, reset, sequence and verdict
    // --------------------------------------------------------
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("All tests passed");
        end
        else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        clk_sys_in = 1'b0;
        forever #5 clk_sys_in = ~clk_sys_in;
    end
    // Whole run is a few thousand cycles; this cuts a hang short
    initial begin
        repeat (20000) @(posedge clk_sys_in);
        miscompares++;
        $display("[ERR] watchdog expected done seen hang");
        tally_and_finish;
    end
    initial begin
        rst_n_in = 1'b0;
        read_in = 1'b0;
        write_in = 1'b0;
        address_in = 5'h00;
        writedata_in = 32'h0;
        hold_sda = 1'b0;
        hold_scl = 1'b0;
        repeat (4) @(posedge clk_sys_in);
        rst_n_in <= 1'b1;
        t_regs;
        t_start(8'h03);
        t_stop(8'h03);
        t_start(8'h05);
        t_stop(8'h05);
        t_coll_start;
        t_early;
        t_restart(1'b0);
        t_restart(1'b1);
        t_late(8'h01, 1'b1, 5);
        t_late(8'h02, 1'b1, 30);
        t_late(8'h04, 1'b1, 5);
        t_late(8'h04, 1'b0, 5);
        t_tx(1'b0);
        t_tx(1'b1);
        tally_and_finish;
    end
endmodule
`default_nettype wire
